// ---- src/pfr_regs.sv ----
// config register bank with filter, ack and timeout logic
// Behaviour
// - suppress-ack bit forces no-ack field in transmit
// - auto-ack answers accepted packets that request acknowledgment
// - persistent-receive bit keeps receiver in reception
// - rx almost-full/empty levels, 7 bits, reset 30
// - tx almost-full/empty levels, 7 bits, reset 30
// - timeout combine select: one is OR, zero AND
// - source filter needs source matching own address
// - multicast match accepts destination equal multicast
// - own-address match accepts destination equal tx source
// - checksum filter discards packets failing check
// - source mask selects bits for source filtering
// - dual sync: address registers form secondary sync
// - own address compared to source, sent as destination
// - tx source register sent, compared to destination
// - rx timeout counter and prescaler registers
// - wake-up prescaler and counter registers
// - wake-up reload uses separate reload registers
// - fifteen-bit back-off seed over two registers
// - address filters only with auto filter enabled
// - secondary sync select enables dual sync detection
// - mask bits gate each quality term before combining
// - four-bit max retransmission count, zero means none
`timescale 1ns/100ps
`default_nettype none

module pfr_regs
    import pfr_pkg::*;
#(
    parameter int ADDR_W = 9
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // received packet
    input  wire logic              rx_valid,
    input  wire pfr_rx_pkt_t       rx_pkt,
    output logic                   rx_accept,
    output logic                   rx_discard,
    output logic                   ack_send,
    // timeout quality terms
    input  wire logic              carrier_sense,
    input  wire logic              sync_quality,
    input  wire logic              preamble_quality,
    output logic                   rx_timeout_stop,
    // transmit header and modes
    output pfr_tx_hdr_t            tx_hdr,
    output logic                   persistent_receive,
    output logic [3:0]             max_retransmissions,
    // secondary sync word
    output logic                   dual_sync_enable,
    output logic [31:0]            secondary_sync_word,
    // fifo levels
    output logic [6:0]             rx_full_level,
    output logic [6:0]             rx_empty_level,
    output logic [6:0]             tx_full_level,
    output logic [6:0]             tx_empty_level,
    // timers
    output logic [7:0]             rx_timeout_count,
    output logic [7:0]             rx_timeout_prescale,
    input  wire logic              wakeup_reload,
    output logic [7:0]             wakeup_prescale,
    output logic [7:0]             wakeup_count,
    // back-off seed
    output logic [14:0]            backoff_seed
);

    // register storage by slot
    logic [7:0] regs_q [PFR_NUM_REGS];
    logic       ack_q; // bus acknowledge
    logic [7:0] rdata_q; // read data byte
    logic       accept_q; // accept pulse
    logic       discard_q; // discard pulse
    logic       ack_send_q; // auto ack pulse
    logic       stop_q; // timeout stop level
    logic [7:0] wk_presc_q; // wake-up prescale in use
    logic [7:0] wk_count_q; // wake-up count in use

    // decoded bus index and slot
    logic [6:0] bus_idx;
    logic [6:0] slot_wide;
    logic       mapped;
    logic       bus_req;
    assign bus_idx   = wb_adr_i[8:2];
    assign slot_wide = bus_idx - PFR_IDX_FIRST;
    assign mapped    = (bus_idx >= PFR_IDX_FIRST) && (bus_idx <= PFR_IDX_FILTER_CTRL);
    assign bus_req   = wb_cyc_i && wb_stb_i && !ack_q;

    // reset value of a slot
    function automatic logic [7:0] reset_of(input logic [6:0] idx);
        unique case (idx)
            PFR_IDX_ACK_RETX_CTRL:     reset_of = PFR_RST_ACK_RETX_CTRL;
            PFR_IDX_RX_FULL_LEVEL,
            PFR_IDX_RX_EMPTY_LEVEL,
            PFR_IDX_TX_FULL_LEVEL,
            PFR_IDX_TX_EMPTY_LEVEL:    reset_of = PFR_RST_FIFO_LEVEL;
            PFR_IDX_RX_FILTER_OPTIONS: reset_of = PFR_RST_RX_FILTER_OPTIONS;
            PFR_IDX_RX_TIMEOUT_COUNT:  reset_of = PFR_RST_RX_TIMEOUT_COUNT;
            PFR_IDX_WAKEUP_PRESC:      reset_of = PFR_RST_WAKEUP_PRESC;
            PFR_IDX_WAKEUP_RLD_PRESC:  reset_of = PFR_RST_WAKEUP_RLD_PRESC;
            PFR_IDX_SEED_HIGH:         reset_of = PFR_RST_SEED_HIGH;
            default:                   reset_of = PFR_RST_ZERO;
        endcase
    endfunction

    // implemented bits of a slot
    function automatic logic [7:0] mask_of(input logic [6:0] idx);
        unique case (idx)
            PFR_IDX_ACK_RETX_CTRL:     mask_of = PFR_MSK_ACK_RETX_CTRL;
            PFR_IDX_RX_FULL_LEVEL,
            PFR_IDX_RX_EMPTY_LEVEL,
            PFR_IDX_TX_FULL_LEVEL,
            PFR_IDX_TX_EMPTY_LEVEL,
            PFR_IDX_SEED_HIGH:         mask_of = PFR_MSK_SEVEN_BITS;
            PFR_IDX_RX_FILTER_OPTIONS: mask_of = PFR_MSK_RX_FILTER_OPTIONS;
            PFR_IDX_FILTER_CTRL:       mask_of = PFR_MSK_FILTER_CTRL;
            default:                   mask_of = PFR_MSK_FULL;
        endcase
    endfunction

    // slot lookup by register index
    function automatic int slot(input logic [6:0] idx);
        slot = int'(idx - PFR_IDX_FIRST);
    endfunction

    // named register views
    logic [7:0] ack_ctrl;
    logic [7:0] flt_opt;
    logic [7:0] flt_ctrl;
    logic [7:0] src_mask;
    logic [7:0] own_addr;
    logic [7:0] bcast_addr;
    logic [7:0] mcast_addr;
    logic [7:0] txsrc_addr;
    assign ack_ctrl   = regs_q[slot(PFR_IDX_ACK_RETX_CTRL)];
    assign flt_opt    = regs_q[slot(PFR_IDX_RX_FILTER_OPTIONS)];
    assign flt_ctrl   = regs_q[slot(PFR_IDX_FILTER_CTRL)];
    assign src_mask   = regs_q[slot(PFR_IDX_SOURCE_MASK)];
    assign own_addr   = regs_q[slot(PFR_IDX_OWN_ADDRESS)];
    assign bcast_addr = regs_q[slot(PFR_IDX_BROADCAST)];
    assign mcast_addr = regs_q[slot(PFR_IDX_MULTICAST)];
    assign txsrc_addr = regs_q[slot(PFR_IDX_TX_SOURCE)];

    // register writes, byte lane 0 only
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < PFR_NUM_REGS; i++)
            begin
                regs_q[i] <= reset_of(7'(i) + PFR_IDX_FIRST);
            end
        end
        else if (bus_req && wb_we_i && wb_sel_i[0] && mapped)
        begin
            regs_q[slot_wide[4:0]] <= wb_dat_i[7:0] & mask_of(bus_idx);
        end
    end

    // one-cycle bus acknowledge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= bus_req;
        end
    end

    // read data; unmapped reads zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_q <= 8'h00;
        end
        else if (bus_req && !wb_we_i)
        begin
            rdata_q <= mapped ? regs_q[slot_wide[4:0]] : 8'h00;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = {24'h00_0000, rdata_q};

    // dual sync and filter enables
    logic auto_flt;
    logic dual_sync;
    assign auto_flt  = flt_ctrl[PFR_BIT_AUTO_FILTER_ENABLE];
    assign dual_sync = flt_ctrl[PFR_BIT_SECONDARY_SYNC_SEL];

    // address checks on rx header
    logic src_ok;
    logic dst_any_en;
    logic dst_hit;
    logic addr_ok;
    logic crc_ok;
    always_comb
    begin
        src_ok = !flt_opt[PFR_BIT_SOURCE_FILTER]
                 || ((rx_pkt.source & src_mask) == (own_addr & src_mask));
        dst_any_en = flt_opt[PFR_BIT_BROADCAST_MATCH] || flt_opt[PFR_BIT_MULTICAST_MATCH]
                     || flt_opt[PFR_BIT_OWN_ADDRESS_MATCH];
        dst_hit = (flt_opt[PFR_BIT_BROADCAST_MATCH] && (rx_pkt.dest == bcast_addr))
                  || (flt_opt[PFR_BIT_MULTICAST_MATCH] && (rx_pkt.dest == mcast_addr))
                  || (flt_opt[PFR_BIT_OWN_ADDRESS_MATCH] && (rx_pkt.dest == txsrc_addr));
        // no address filtering in dual sync
        addr_ok = !auto_flt || dual_sync || (src_ok && (!dst_any_en || dst_hit));
        crc_ok = !flt_opt[PFR_BIT_CHECKSUM_FILTER] || rx_pkt.checksum_ok;
    end

    // verdict pulse per packet
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            accept_q  <= 1'b0;
            discard_q <= 1'b0;
        end
        else
        begin
            accept_q  <= rx_valid && addr_ok && crc_ok;
            discard_q <= rx_valid && !(addr_ok && crc_ok);
        end
    end

    // auto ack of accepted packets
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_send_q <= 1'b0;
        end
        else
        begin
            ack_send_q <= rx_valid && addr_ok && crc_ok && rx_pkt.ack_request
                          && ack_ctrl[PFR_BIT_AUTO_ACK];
        end
    end

    assign rx_accept  = accept_q;
    assign rx_discard = discard_q;
    assign ack_send   = ack_send_q;

    // quality terms to timeout stop
    logic [2:0] q_val;
    logic [2:0] q_msk;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stop_q <= 1'b0;
        end
        else if (q_msk == 3'b000)
        begin
            // no term selected
            stop_q <= 1'b0;
        end
        else if (flt_opt[PFR_BIT_TIMEOUT_OR_SEL])
        begin
            stop_q <= |(q_val & q_msk);
        end
        else
        begin
            stop_q <= &(q_val | ~q_msk);
        end
    end

    assign q_msk = {flt_ctrl[PFR_BIT_CS_TIMEOUT_MASK], flt_ctrl[PFR_BIT_SQ_TIMEOUT_MASK],
                    flt_ctrl[PFR_BIT_PQ_TIMEOUT_MASK]};
    assign q_val = {carrier_sense, sync_quality, preamble_quality};
    assign rx_timeout_stop = stop_q;

    // wake-up values, reload set on reload
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wk_presc_q <= PFR_RST_WAKEUP_PRESC;
            wk_count_q <= PFR_RST_ZERO;
        end
        else if (wakeup_reload)
        begin
            wk_presc_q <= regs_q[slot(PFR_IDX_WAKEUP_RLD_PRESC)];
            wk_count_q <= regs_q[slot(PFR_IDX_WAKEUP_RLD_COUNT)];
        end
        else
        begin
            wk_presc_q <= regs_q[slot(PFR_IDX_WAKEUP_PRESC)];
            wk_count_q <= regs_q[slot(PFR_IDX_WAKEUP_COUNT)];
        end
    end

    assign wakeup_prescale = wk_presc_q;
    assign wakeup_count    = wk_count_q;

    assign tx_hdr.no_ack = ack_ctrl[PFR_BIT_SUPPRESS_ACK_REQUEST];
    assign tx_hdr.dest   = own_addr;
    assign tx_hdr.source = txsrc_addr;

    assign persistent_receive  = ack_ctrl[PFR_BIT_PERSISTENT_RECEIVE];
    assign max_retransmissions = ack_ctrl[PFR_POS_MAX_RETX_HI:PFR_POS_MAX_RETX_LO];

    assign dual_sync_enable    = dual_sync;
    assign secondary_sync_word = {own_addr, bcast_addr, mcast_addr, txsrc_addr};

    assign rx_full_level  = regs_q[slot(PFR_IDX_RX_FULL_LEVEL)][6:0];
    assign rx_empty_level = regs_q[slot(PFR_IDX_RX_EMPTY_LEVEL)][6:0];
    assign tx_full_level  = regs_q[slot(PFR_IDX_TX_FULL_LEVEL)][6:0];
    assign tx_empty_level = regs_q[slot(PFR_IDX_TX_EMPTY_LEVEL)][6:0];

    assign rx_timeout_count    = regs_q[slot(PFR_IDX_RX_TIMEOUT_COUNT)];
    assign rx_timeout_prescale = regs_q[slot(PFR_IDX_RX_TIMEOUT_PRESC)];

    assign backoff_seed = {regs_q[slot(PFR_IDX_SEED_HIGH)][6:0], regs_q[slot(PFR_IDX_SEED_LOW)]};

endmodule

`default_nettype wire

// ---- src/pfr_pkg.sv ----
// constants and carrier types of the filter config bank
package pfr_pkg;

    // register indices; byte address is 4 * index
    localparam logic [6:0] PFR_IDX_ACK_RETX_CTRL     = 7'h3B;
    localparam logic [6:0] PFR_IDX_RX_FULL_LEVEL     = 7'h3C;
    localparam logic [6:0] PFR_IDX_RX_EMPTY_LEVEL    = 7'h3D;
    localparam logic [6:0] PFR_IDX_TX_FULL_LEVEL     = 7'h3E;
    localparam logic [6:0] PFR_IDX_TX_EMPTY_LEVEL    = 7'h3F;
    localparam logic [6:0] PFR_IDX_RX_FILTER_OPTIONS = 7'h40;
    localparam logic [6:0] PFR_IDX_SOURCE_MASK       = 7'h41;
    localparam logic [6:0] PFR_IDX_OWN_ADDRESS       = 7'h42;
    localparam logic [6:0] PFR_IDX_BROADCAST         = 7'h43;
    localparam logic [6:0] PFR_IDX_MULTICAST         = 7'h44;
    localparam logic [6:0] PFR_IDX_TX_SOURCE         = 7'h45;
    localparam logic [6:0] PFR_IDX_RX_TIMEOUT_COUNT  = 7'h46;
    localparam logic [6:0] PFR_IDX_RX_TIMEOUT_PRESC  = 7'h47;
    localparam logic [6:0] PFR_IDX_WAKEUP_PRESC      = 7'h48;
    localparam logic [6:0] PFR_IDX_WAKEUP_COUNT      = 7'h49;
    localparam logic [6:0] PFR_IDX_WAKEUP_RLD_PRESC  = 7'h4A;
    localparam logic [6:0] PFR_IDX_WAKEUP_RLD_COUNT  = 7'h4B;
    localparam logic [6:0] PFR_IDX_SEED_HIGH         = 7'h4C;
    localparam logic [6:0] PFR_IDX_SEED_LOW          = 7'h4D;
    localparam logic [6:0] PFR_IDX_FILTER_CTRL       = 7'h4E;
    localparam logic [6:0] PFR_IDX_FIRST             = 7'h3B;
    localparam int         PFR_NUM_REGS              = 20;

    // reset values
    localparam logic [7:0] PFR_RST_ACK_RETX_CTRL     = 8'h08;
    localparam logic [7:0] PFR_RST_FIFO_LEVEL        = 8'h30;
    localparam logic [7:0] PFR_RST_RX_FILTER_OPTIONS = 8'h40;
    localparam logic [7:0] PFR_RST_RX_TIMEOUT_COUNT  = 8'h01;
    localparam logic [7:0] PFR_RST_WAKEUP_PRESC      = 8'h01;
    localparam logic [7:0] PFR_RST_WAKEUP_RLD_PRESC  = 8'h01;
    localparam logic [7:0] PFR_RST_SEED_HIGH         = 8'h4C;
    localparam logic [7:0] PFR_RST_ZERO              = 8'h00;

    // writable-bit masks
    localparam logic [7:0] PFR_MSK_ACK_RETX_CTRL     = 8'hFE;
    localparam logic [7:0] PFR_MSK_SEVEN_BITS        = 8'h7F;
    localparam logic [7:0] PFR_MSK_RX_FILTER_OPTIONS = 8'h5F;
    localparam logic [7:0] PFR_MSK_FILTER_CTRL       = 8'hE3;
    localparam logic [7:0] PFR_MSK_FULL              = 8'hFF;

    // ack/retransmission control fields
    localparam int PFR_BIT_SUPPRESS_ACK_REQUEST = 3;
    localparam int PFR_BIT_AUTO_ACK             = 2;
    localparam int PFR_BIT_PERSISTENT_RECEIVE   = 1;
    localparam int PFR_POS_MAX_RETX_HI          = 7;
    localparam int PFR_POS_MAX_RETX_LO          = 4;

    // filter option fields
    localparam int PFR_BIT_TIMEOUT_OR_SEL       = 6;
    localparam int PFR_BIT_SOURCE_FILTER        = 4;
    localparam int PFR_BIT_BROADCAST_MATCH      = 3;
    localparam int PFR_BIT_MULTICAST_MATCH      = 2;
    localparam int PFR_BIT_OWN_ADDRESS_MATCH    = 1;
    localparam int PFR_BIT_CHECKSUM_FILTER      = 0;

    // filter control fields
    localparam int PFR_BIT_CS_TIMEOUT_MASK      = 7;
    localparam int PFR_BIT_SQ_TIMEOUT_MASK      = 6;
    localparam int PFR_BIT_PQ_TIMEOUT_MASK      = 5;
    localparam int PFR_BIT_SECONDARY_SYNC_SEL   = 1;
    localparam int PFR_BIT_AUTO_FILTER_ENABLE   = 0;

    // received header from the packet engine
    typedef struct packed {
        logic [7:0] source;
        logic [7:0] dest;
        logic       checksum_ok;
        logic       ack_request;
    } pfr_rx_pkt_t;

    // header fields for transmission
    typedef struct packed {
        logic [7:0] dest;
        logic [7:0] source;
        logic       no_ack;
    } pfr_tx_hdr_t;

endpackage

// ---- testbench/pfr_regs_monitor.sv ----
// assertion checker for the filter config bank
`timescale 1ns/100ps
`default_nettype none
module pfr_regs_monitor
    import pfr_pkg::*;
#(
    parameter int ADDR_W = 9
)
(
    // clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // register bus
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    // packet path
    input wire logic              rx_valid,
    input wire pfr_rx_pkt_t       rx_pkt,
    input wire logic              rx_accept,
    input wire logic              rx_discard,
    input wire logic              ack_send,
    // transmit side
    input wire pfr_tx_hdr_t       tx_hdr,
    input wire logic              persistent_receive,
    input wire logic [3:0]        max_retransmissions
);
    logic [7:0] ack_ctl_q; // shadow of ack control
    logic [7:0] opt_q;     // shadow of filter options
    logic       take_wr;   // write taken at this edge
    logic       unmapped;  // index outside the bank
    assign take_wr  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign unmapped = (wb_adr_i[ADDR_W-1:2] < PFR_IDX_FIRST) || (wb_adr_i[ADDR_W-1:2] > PFR_IDX_FILTER_CTRL);

    // shadows of checked registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_ctl_q <= PFR_RST_ACK_RETX_CTRL;
            opt_q     <= PFR_RST_RX_FILTER_OPTIONS;
        end
        else if (take_wr && wb_adr_i[ADDR_W-1:2] == PFR_IDX_ACK_RETX_CTRL)
        begin
            ack_ctl_q <= wb_dat_i[7:0] & PFR_MSK_ACK_RETX_CTRL;
        end
        else if (take_wr && wb_adr_i[ADDR_W-1:2] == PFR_IDX_RX_FILTER_OPTIONS)
        begin
            opt_q <= wb_dat_i[7:0] & PFR_MSK_RX_FILTER_OPTIONS;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_read_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && unmapped |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_rx_one_result: assert property (rx_valid |=> rx_accept != rx_discard)
        else $error("not one rx result");
    a_rx_quiet: assert property (!rx_valid |=> !(rx_accept || rx_discard || ack_send))
        else $error("result without packet");
    a_ack_needs_accept: assert property (ack_send |-> rx_accept)
        else $error("ack without accept");
    a_crc_discard: assert property (rx_valid && opt_q[0] && !rx_pkt.checksum_ok |=> rx_discard && !ack_send)
        else $error("bad checksum kept");
    a_no_ack_field: assert property (tx_hdr.no_ack == ack_ctl_q[3])
        else $error("no-ack field wrong");
    a_mode_fields: assert property ({persistent_receive, max_retransmissions} == {ack_ctl_q[1], ack_ctl_q[7:4]})
        else $error("mode outputs wrong");

    c_accept: cover property (rx_valid ##1 rx_accept);
    c_discard: cover property (rx_valid ##1 rx_discard);
    c_ack_send: cover property (ack_send);
    c_read: cover property (wb_ack_o && !wb_we_i);
endmodule

bind pfr_regs pfr_regs_monitor #(.ADDR_W(ADDR_W)) u_pfr_mon
(
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_valid(rx_valid), .rx_pkt(rx_pkt), .rx_accept(rx_accept),
    .rx_discard(rx_discard), .ack_send(ack_send), .tx_hdr(tx_hdr),
    .persistent_receive(persistent_receive), .max_retransmissions(max_retransmissions)
);
`default_nettype wire

// ---- testbench/pfr_host.sv ----
// host model: wishbone classic master
`timescale 1ns/100ps
`default_nettype none
module pfr_host
(
    // clock
    input wire logic     clk,
    // wishbone master
    output var logic        wb_cyc_o = 1'b0,
    output var logic        wb_stb_o = 1'b0,
    output var logic        wb_we_o  = 1'b0,
    output var logic [8:0]  wb_adr_o = 9'h000,
    output var logic [3:0]  wb_sel_o = 4'h0,
    output var logic [31:0] wb_dat_o = 32'h0000_0000,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_i
);
    int slow_cycles = 0; // one less than the idle cycles before each request

    // one classic cycle; late if no ack
    task automatic xfer(input logic w, input logic [6:0] idx, input logic [7:0] d, input logic lane0,
                        output logic late);
        int n;
        n = 0;
        repeat (slow_cycles + 1) @(posedge clk);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= w;
        wb_adr_o <= {idx, 2'b00};
        wb_sel_o <= {3'b000, lane0};
        wb_dat_o <= {24'h00_0000, d};
        // hold until ack seen at an edge
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_i !== 1'b1 && n < 20);
        late = (wb_ack_i !== 1'b1);
        // released lines show the inverse
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_adr_o <= ~wb_adr_o;
        wb_dat_o <= ~wb_dat_o;
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the filter config bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pfr_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, rx_valid = 1'b0, wakeup_reload = 1'b0;
    logic        carrier_sense = 1'b0, sync_quality = 1'b0, preamble_quality = 1'b0;
    pfr_rx_pkt_t rx_pkt = '0;
    logic        cyc, stb, we, ack, acc, dis, asend, tstop, pers, dsync, late;
    logic [8:0]  adr;
    logic [3:0]  sel, mretx;
    logic [31:0] dat_w, dat_r, ssw;
    pfr_tx_hdr_t hdr;
    logic [6:0]  rfl, rel, tfl, tel;
    logic [7:0]  rtc, rtp, wkp, wkc;
    logic [14:0] seed;
    logic [15:0] lf = 16'h0003; // stimulus generator state
    int          error_cnt = 0, tests_run = 0;
    logic [31:0] rd_q [$]; // expected read data
    logic [2:0]  rx_q [$]; // expected accept, discard, ack
    logic [7:0]  rst_tab [20] = '{8'h08, 8'h30, 8'h30, 8'h30, 8'h30, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
                                  8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h4C, 8'h00, 8'h00};
    logic [7:0]  msk_tab [20] = '{8'hFE, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h5F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                  8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hE3};
    logic [7:0]  regs [20]; // expected register contents
    logic [7:0]  opt_tab [5] = '{8'h1F, 8'h10, 8'h04, 8'h0B, 8'h11};
    logic [7:0]  ctl_tab [5] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h00};

    initial
    begin
        forever #20 clk = ~clk;
    end

    pfr_host host (.clk(clk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
                   .wb_sel_o(sel), .wb_dat_o(dat_w), .wb_dat_i(dat_r), .wb_ack_i(ack));

    pfr_regs dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .rx_valid(rx_valid),
        .rx_pkt(rx_pkt), .rx_accept(acc), .rx_discard(dis), .ack_send(asend), .carrier_sense(carrier_sense),
        .sync_quality(sync_quality), .preamble_quality(preamble_quality), .rx_timeout_stop(tstop),
        .tx_hdr(hdr), .persistent_receive(pers), .max_retransmissions(mretx), .dual_sync_enable(dsync),
        .secondary_sync_word(ssw), .rx_full_level(rfl), .rx_empty_level(rel), .tx_full_level(tfl),
        .tx_empty_level(tel), .rx_timeout_count(rtc), .rx_timeout_prescale(rtp),
        .wakeup_reload(wakeup_reload), .wakeup_prescale(wkp), .wakeup_count(wkc), .backoff_seed(seed));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic report_and_stop();
        if (error_cnt == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            error_cnt++;
        end
    endtask

    // unmapped or lane-off writes change nothing
    task automatic wr(input logic [6:0] idx, input logic [7:0] d, input logic lane0);
        if (lane0 && idx >= PFR_IDX_FIRST && idx <= PFR_IDX_FILTER_CTRL)
            regs[idx - PFR_IDX_FIRST] = d & msk_tab[idx - PFR_IDX_FIRST];
        host.xfer(1'b1, idx, d, lane0, late);
        if (late)
        begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    task automatic rd(input logic [6:0] idx);
        rd_q.push_back((idx >= PFR_IDX_FIRST && idx <= PFR_IDX_FILTER_CTRL) ? regs[idx - PFR_IDX_FIRST] : 8'h00);
        host.xfer(1'b0, idx, 8'h00, 1'b1, late);
        if (late)
        begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    // one packet per cycle, expected from settings
    task automatic send(input logic [7:0] s, input logic [7:0] d, input logic ck, input logic rq);
        logic src_ok, hit, ok;
        src_ok = !regs[5][4] || ((s & regs[6]) == (regs[7] & regs[6]));
        hit = (regs[5][3] && d == regs[8]) || (regs[5][2] && d == regs[9]) || (regs[5][1] && d == regs[10]);
        ok = (!regs[19][0] || regs[19][1] || (src_ok && (regs[5][3:1] == 3'h0 || hit))) && (!regs[5][0] || ck);
        rx_q.push_back({ok, !ok, ok && rq && regs[0][2]});
        rx_pkt <= {s, d, ck, rq};
        rx_valid <= 1'b1;
        @(posedge clk);
    endtask

    task automatic check_static();
        check("tx header", hdr, {regs[7], regs[10], regs[0][3]});
        check("mode fields", {pers, mretx}, {regs[0][1], regs[0][7:4]});
        check("sync word", ssw, {regs[7], regs[8], regs[9], regs[10]});
        check("dual sync", dsync, regs[19][1]);
        check("levels", {rfl, rel, tfl, tel}, {regs[1][6:0], regs[2][6:0], regs[3][6:0], regs[4][6:0]});
        check("rx timer", {rtc, rtp}, {regs[11], regs[12]});
        check("wakeup", {wkp, wkc}, {regs[13], regs[14]});
        check("seed", seed, {regs[17][6:0], regs[18]});
    endtask

    // pops the oldest note per result
    always @(posedge clk)
    begin
        if (ack === 1'b1 && we === 1'b0)
            check("read data", dat_r, (rd_q.size() > 0) ? rd_q.pop_front() : 32'hDEAD_BEEF);
        if (acc === 1'b1 || dis === 1'b1)
            check("rx result", {acc, dis, asend}, (rx_q.size() > 0) ? rx_q.pop_front() : 3'h7);
    end

    initial
    begin
        logic [7:0] s, d;
        regs = rst_tab;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int r = 0; r < 3; r++)
        begin
            host.slow_cycles = r * 3;
            for (int i = 0; i < 20; i++)
                rd(PFR_IDX_FIRST + 7'(i));
            rd(7'h3A);
            wr(7'h4F, 8'hFF, 1'b1);
            rd(7'h4F);
            for (int i = 0; i < 20 && r < 2; i++)
            begin
                lf = lfsr_next(lf);
                wr(PFR_IDX_FIRST + 7'(i), lf[7:0], lf[8]);
            end
            repeat (2) @(posedge clk);
            check_static();
        end
        // wake-up reload source
        wakeup_reload <= 1'b1;
        repeat (2) @(posedge clk);
        check("reload", {wkp, wkc}, {regs[15], regs[16]});
        wakeup_reload <= 1'b0;
        // acceptance under filter settings
        for (int k = 0; k < 5; k++)
        begin
            wr(PFR_IDX_ACK_RETX_CTRL, k[0] ? 8'h00 : 8'h04, 1'b1);
            wr(PFR_IDX_RX_FILTER_OPTIONS, opt_tab[k], 1'b1);
            wr(PFR_IDX_FILTER_CTRL, ctl_tab[k], 1'b1);
            for (int p = 0; p < 16; p++)
            begin
                lf = lfsr_next(lf);
                s = lf[2] ? lf[15:8] : regs[7 + lf[1:0]];
                d = lf[5] ? lf[15:8] ^ 8'h5A : regs[7 + lf[4:3]];
                send(s, d, lf[6], lf[7]);
            end
            rx_valid <= 1'b0;
        end
        // timeout combine over all masks, both functions
        for (int k = 0; k < 16; k++)
        begin
            wr(PFR_IDX_FILTER_CTRL, {k[2:0], 5'h00}, 1'b1);
            wr(PFR_IDX_RX_FILTER_OPTIONS, {1'b0, k[3], 6'h00}, 1'b1);
            for (int t = 0; t < 8; t++)
            begin
                {carrier_sense, sync_quality, preamble_quality} <= t[2:0];
                repeat (2) @(posedge clk);
                check("timeout stop", tstop, (k[2:0] == 0) ? 1'b0 : k[3] ? |(t[2:0] & k[2:0]) : &(t[2:0] | ~k[2:0]));
            end
        end
        repeat (4) @(posedge clk);
        check("pending notes", rd_q.size() + rx_q.size(), 32'h0000_0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
